// >>> rtl/crs_pkg.sv
// Package: constants, types and stack pointer step function for the CPU register set and stack
package crs_pkg;
  localparam logic [15:0] CRS_SP_RESET = 16'h017f;
  localparam logic [8:0] CRS_SP_HIGH_FIXED = 9'h002;
  localparam logic [15:0] CRS_RESET_VEC_LO = 16'hfffe;
  localparam logic [15:0] CRS_RESET_VEC_HI = 16'hffff;
  localparam logic [7:0] CRS_CC_RESET = 8'he8;
  localparam int CRS_BIT_H = 4;
  localparam int CRS_BIT_I = 3;
  localparam int CRS_BIT_N = 2;
  localparam int CRS_BIT_Z = 1;
  localparam int CRS_BIT_C = 0;
  localparam int CRS_STARTUP_CYCLES = 4096;
  localparam logic [2:0] CRS_CALL_BYTES = 3'h2;
  localparam logic [2:0] CRS_INT_BYTES = 3'h5;

  typedef enum logic [3:0]
  {
    CRS_OP_NONE = 4'h0,
    CRS_OP_ALU = 4'h1,
    CRS_OP_ADD = 4'h2,
    CRS_OP_CARRY_SET = 4'h3,
    CRS_OP_CARRY_CLEAR = 4'h4,
    CRS_OP_MASK_SET = 4'h5,
    CRS_OP_MASK_CLEAR = 4'h6,
    CRS_OP_SP_RELOAD = 4'h7,
    CRS_OP_SP_LOAD = 4'h8,
    CRS_OP_PUSH = 4'h9,
    CRS_OP_POP = 4'ha,
    CRS_OP_CALL = 4'hb,
    CRS_OP_RET = 4'hc,
    CRS_OP_INT_ENTRY = 4'hd,
    CRS_OP_INT_RETURN = 4'he,
    CRS_OP_CC_LOAD = 4'hf
  } crs_op_t;

  typedef struct packed
  {
    crs_op_t op;
    logic [7:0] result;
    logic carry;
    logic half_carry;
    logic carry_valid;
    logic [1:0] dest;
    logic [15:0] data;
  } crs_cmd_t;

  typedef struct packed
  {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crs_mem_t;

  localparam logic [1:0] CRS_DEST_ACC = 2'h0;
  localparam logic [1:0] CRS_DEST_X = 2'h1;
  localparam logic [1:0] CRS_DEST_Y = 2'h2;
  localparam logic [1:0] CRS_DEST_PC = 2'h3;

  // Next stack address with the fixed upper bits restored
  function automatic logic [15:0] crs_sp_step(input logic [15:0] sp, input logic dec);
    logic [6:0] low;
    low = dec ? sp[6:0] - 7'h01 : sp[6:0] + 7'h01;
    return {CRS_SP_HIGH_FIXED, low};
  endfunction
endpackage

// >>> rtl/crs_reset_ctrl.sv
// Reset sequencer: pin synchroniser, start-up hold and reset pin drive
`timescale 1ns/1ps
module crs_reset_ctrl
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Internal reset sources
  input wire logic watchdog_reset,
  input wire logic low_voltage_reset,
  // Core held while high
  output logic core_hold
);
  import crs_pkg::*;
  logic pin_s1_r, pin_s2_r;
  logic [12:0] cnt_r, cnt_nxt;
  logic drive;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      cnt_r <= 13'h0000;
    end
    else
    begin
      pin_s1_r <= reset_pin_in;
      pin_s2_r <= pin_s1_r;
      cnt_r <= cnt_nxt;
    end
  end

  always_comb
  begin
    drive = watchdog_reset | low_voltage_reset;
    cnt_nxt = cnt_r;
    if (drive || !pin_s2_r)
      cnt_nxt = 13'h0000;
    else if (cnt_r < 13'(CRS_STARTUP_CYCLES))
      cnt_nxt = cnt_r + 13'h0001;
  end

  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = drive;
  assign core_hold = cnt_r < 13'(CRS_STARTUP_CYCLES);
endmodule

// >>> rtl/crs_flag_unit.sv
// Condition flag update unit
`timescale 1ns/1ps
module crs_flag_unit
(
  // Current flags and command
  input crs_pkg::crs_cmd_t cmd,
  input wire logic [7:0] flags,
  // Updated flags
  output logic [7:0] flags_nxt
);
  import crs_pkg::*;

  always_comb
  begin
    flags_nxt = flags;
    unique case (cmd.op)
      CRS_OP_ADD, CRS_OP_ALU:
      begin
        flags_nxt[CRS_BIT_N] = cmd.result[7];
        flags_nxt[CRS_BIT_Z] = cmd.result == 8'h00;
        if (cmd.carry_valid)
          flags_nxt[CRS_BIT_C] = cmd.carry;
        if (cmd.op == CRS_OP_ADD)
          flags_nxt[CRS_BIT_H] = cmd.half_carry;
      end
      CRS_OP_CARRY_SET: flags_nxt[CRS_BIT_C] = 1'b1;
      CRS_OP_CARRY_CLEAR: flags_nxt[CRS_BIT_C] = 1'b0;
      CRS_OP_MASK_SET, CRS_OP_INT_ENTRY: flags_nxt[CRS_BIT_I] = 1'b1;
      CRS_OP_MASK_CLEAR: flags_nxt[CRS_BIT_I] = 1'b0;
      CRS_OP_CC_LOAD: flags_nxt = {3'b111, cmd.data[4:0]};
      default: flags_nxt = flags;
    endcase
  end
endmodule

// >>> rtl/crs_core_regs.sv
// CPU register set, stack sequencer and reset vector fetch
`timescale 1ns/1ps
module crs_core_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Reset pin and internal reset sources
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_reset,
  input wire logic low_voltage_reset,
  // Command from decode
  input crs_pkg::crs_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  // Interrupt requests
  input wire logic int_req,
  input wire logic [15:0] int_vector,
  output logic int_taken,
  // Memory port, reads return next cycle
  output crs_pkg::crs_mem_t mem,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  // Architectural state
  output logic [7:0] accumulator,
  output logic [7:0] index_x,
  output logic [7:0] index_y,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags,
  output logic [15:0] stack_pointer,
  output logic running
);
  import crs_pkg::*;

  typedef enum logic [3:0]
  {
    CRS_ST_HOLD = 4'h0,
    CRS_ST_VEC_HI = 4'h1,
    CRS_ST_VEC_LO = 4'h2,
    CRS_ST_VEC_END = 4'h3,
    CRS_ST_IDLE = 4'h4,
    CRS_ST_PUSH = 4'h5,
    CRS_ST_POP = 4'h6,
    CRS_ST_POP_END = 4'h7
  } crs_state_t;

  crs_state_t state_r, state_nxt;
  logic [7:0] acc_r, acc_nxt, x_r, x_nxt, y_r, y_nxt;
  logic [7:0] pcl_r, pcl_nxt, pch_r, pch_nxt;
  logic [7:0] cc_r, cc_nxt, cc_alu;
  logic [15:0] sp_r, sp_nxt;
  logic [2:0] step_r, step_nxt, len_r, len_nxt;
  logic is_int_r, is_int_nxt;
  logic pend_r, pend_nxt;
  logic [15:0] ivec_r, ivec_nxt;
  logic core_hold;
  crs_mem_t mem_nxt;
  logic mem_re_nxt;

  crs_reset_ctrl u_reset
  (
    .clk(clk),
    .arst_n(arst_n),
    .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe),
    .watchdog_reset(watchdog_reset),
    .low_voltage_reset(low_voltage_reset),
    .core_hold(core_hold)
  );

  crs_flag_unit u_flags
  (
    .cmd(cmd),
    .flags(cc_r),
    .flags_nxt(cc_alu)
  );

  // Byte pushed at a given step of an interrupt or call frame
  function automatic logic [7:0] push_byte(input logic [2:0] step);
    unique case (step)
      3'h0: return pcl_r;
      3'h1: return pch_r;
      3'h2: return x_r;
      3'h3: return acc_r;
      default: return cc_r;
    endcase
  endfunction

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= CRS_ST_HOLD;
      acc_r <= 8'h00;
      x_r <= 8'h00;
      y_r <= 8'h00;
      pcl_r <= 8'h00;
      pch_r <= 8'h00;
      cc_r <= CRS_CC_RESET;
      sp_r <= CRS_SP_RESET;
      step_r <= 3'h0;
      len_r <= 3'h0;
      is_int_r <= 1'b0;
      pend_r <= 1'b0;
      ivec_r <= 16'h0000;
      mem <= '0;
      mem_re <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      pcl_r <= pcl_nxt;
      pch_r <= pch_nxt;
      cc_r <= cc_nxt;
      sp_r <= sp_nxt;
      step_r <= step_nxt;
      len_r <= len_nxt;
      is_int_r <= is_int_nxt;
      pend_r <= pend_nxt;
      ivec_r <= ivec_nxt;
      mem <= mem_nxt;
      mem_re <= mem_re_nxt;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    x_nxt = x_r;
    y_nxt = y_r;
    pcl_nxt = pcl_r;
    pch_nxt = pch_r;
    cc_nxt = cc_r;
    sp_nxt = sp_r;
    step_nxt = step_r;
    len_nxt = len_r;
    is_int_nxt = is_int_r;
    pend_nxt = pend_r | int_req;
    ivec_nxt = int_req ? int_vector : ivec_r;
    mem_nxt = '0;
    mem_re_nxt = 1'b0;
    int_taken = 1'b0;
    cmd_ready = 1'b0;
    if (core_hold)
    begin
      state_nxt = CRS_ST_HOLD;
      sp_nxt = CRS_SP_RESET;
      cc_nxt = CRS_CC_RESET;
    end
    else
    begin
      unique case (state_r)
        CRS_ST_HOLD:
        begin
          mem_nxt.addr = CRS_RESET_VEC_LO;
          mem_re_nxt = 1'b1;
          state_nxt = CRS_ST_VEC_HI;
        end
        CRS_ST_VEC_HI:
        begin
          mem_nxt.addr = CRS_RESET_VEC_HI;
          mem_re_nxt = 1'b1;
          pch_nxt = mem_rdata;
          state_nxt = CRS_ST_VEC_LO;
        end
        CRS_ST_VEC_LO:
        begin
          pcl_nxt = mem_rdata;
          state_nxt = CRS_ST_VEC_END;
        end
        CRS_ST_VEC_END:
          state_nxt = CRS_ST_IDLE;
        CRS_ST_IDLE:
        begin
          if (pend_r && !cc_r[CRS_BIT_I])
          begin
            // Masked requests stay pending until the mask clears
            int_taken = 1'b1;
            pend_nxt = int_req;
            is_int_nxt = 1'b1;
            len_nxt = CRS_INT_BYTES;
            step_nxt = 3'h0;
            state_nxt = CRS_ST_PUSH;
          end
          else if (cmd_valid)
          begin
            cmd_ready = 1'b1;
            cc_nxt = cc_alu;
            unique case (cmd.op)
              CRS_OP_ALU, CRS_OP_ADD:
                unique case (cmd.dest)
                  CRS_DEST_ACC: acc_nxt = cmd.result;
                  CRS_DEST_X: x_nxt = cmd.result;
                  CRS_DEST_Y: y_nxt = cmd.result;
                  default: {pch_nxt, pcl_nxt} = cmd.data;
                endcase
              CRS_OP_SP_RELOAD: sp_nxt = CRS_SP_RESET;
              CRS_OP_SP_LOAD: sp_nxt = {CRS_SP_HIGH_FIXED, cmd.data[6:0]};
              CRS_OP_PUSH:
              begin
                mem_nxt.we = 1'b1;
                mem_nxt.addr = sp_r;
                mem_nxt.wdata = cmd.data[7:0];
                sp_nxt = crs_sp_step(sp_r, 1'b1);
              end
              CRS_OP_POP:
              begin
                sp_nxt = crs_sp_step(sp_r, 1'b0);
                mem_nxt.addr = sp_nxt;
                mem_re_nxt = 1'b1;
                is_int_nxt = 1'b0;
                len_nxt = 3'h1;
                step_nxt = 3'h3;
                state_nxt = CRS_ST_POP;
              end
              CRS_OP_CALL:
              begin
                is_int_nxt = 1'b0;
                len_nxt = CRS_CALL_BYTES;
                step_nxt = 3'h0;
                ivec_nxt = cmd.data;
                state_nxt = CRS_ST_PUSH;
              end
              CRS_OP_RET:
              begin
                is_int_nxt = 1'b0;
                len_nxt = CRS_CALL_BYTES;
                step_nxt = 3'h1;
                sp_nxt = crs_sp_step(sp_r, 1'b0);
                mem_nxt.addr = sp_nxt;
                mem_re_nxt = 1'b1;
                state_nxt = CRS_ST_POP;
              end
              CRS_OP_INT_RETURN:
              begin
                is_int_nxt = 1'b1;
                len_nxt = CRS_INT_BYTES;
                step_nxt = 3'h4;
                sp_nxt = crs_sp_step(sp_r, 1'b0);
                mem_nxt.addr = sp_nxt;
                mem_re_nxt = 1'b1;
                state_nxt = CRS_ST_POP;
              end
              default: ;
            endcase
          end
        end
        CRS_ST_PUSH:
        begin
          mem_nxt.we = 1'b1;
          mem_nxt.addr = sp_r;
          mem_nxt.wdata = push_byte(step_r);
          sp_nxt = crs_sp_step(sp_r, 1'b1);
          step_nxt = step_r + 3'h1;
          if (step_r + 3'h1 == len_r)
          begin
            {pch_nxt, pcl_nxt} = ivec_r;
            if (is_int_r)
              cc_nxt[CRS_BIT_I] = 1'b1;
            state_nxt = CRS_ST_IDLE;
          end
        end
        CRS_ST_POP:
        begin
          // Data for the read issued last cycle arrives now
          unique case (step_r)
            3'h4: cc_nxt = {3'b111, mem_rdata[4:0]};
            3'h3: acc_nxt = mem_rdata;
            3'h2: x_nxt = mem_rdata;
            3'h1: pch_nxt = mem_rdata;
            default: pcl_nxt = mem_rdata;
          endcase
          if (step_r == 3'h0 || (len_r == 3'h1))
            state_nxt = CRS_ST_POP_END;
          else
          begin
            step_nxt = step_r - 3'h1;
            sp_nxt = crs_sp_step(sp_r, 1'b0);
            mem_nxt.addr = sp_nxt;
            mem_re_nxt = 1'b1;
          end
        end
        CRS_ST_POP_END:
        begin
          if (is_int_r)
            cc_nxt[CRS_BIT_I] = 1'b0;
          state_nxt = CRS_ST_IDLE;
        end
        default: state_nxt = CRS_ST_HOLD;
      endcase
    end
  end

  assign accumulator = acc_r;
  assign index_x = x_r;
  assign index_y = y_r;
  assign program_counter = {pch_r, pcl_r};
  assign condition_flags = cc_r;
  assign stack_pointer = sp_r;
  assign running = (state_r != CRS_ST_HOLD) && !core_hold;
endmodule

// >>> verification/crs_core_regs_asserts.sv
// Concurrent checks on the register set, stack sequencer and reset pin
`timescale 1ns/1ps
module crs_core_regs_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Reset pin and sources
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic watchdog_reset,
  input wire logic low_voltage_reset,
  // Command and interrupt
  input crs_pkg::crs_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic int_taken,
  // Observed state
  input crs_pkg::crs_mem_t mem,
  input wire logic [7:0] index_y,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] condition_flags,
  input wire logic [15:0] stack_pointer,
  input wire logic running
);
  import crs_pkg::*;
  logic [15:0] ent_sp_r;
  logic [15:0] ent_pc_r;
  logic [15:0] cmd_sp_r;
  logic [15:0] cmd_pc_r;
  logic take;
  assign take = cmd_valid && cmd_ready;
  // Pointer and counter seen when an interrupt frame starts; pointer and command data when a command starts
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ent_sp_r <= 16'h0000;
      ent_pc_r <= 16'h0000;
      cmd_sp_r <= 16'h0000;
      cmd_pc_r <= 16'h0000;
    end
    else
    begin
      if (int_taken)
      begin
        ent_sp_r <= stack_pointer;
        ent_pc_r <= program_counter;
      end
      if (take)
      begin
        cmd_sp_r <= stack_pointer;
        cmd_pc_r <= cmd.data;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_entry;
    int_taken;
  endsequence
  sequence s_frame_done;
    condition_flags[CRS_BIT_I] && stack_pointer == {CRS_SP_HIGH_FIXED, ent_sp_r[6:0] - 7'h05};
  endsequence
  sequence s_first_write;
    mem.we && mem.addr == ent_sp_r && mem.wdata == ent_pc_r[7:0];
  endsequence
  a_pin_drive_src: assert property (reset_pin_oe == (watchdog_reset || low_voltage_reset))
    else $error("reset pin drive does not follow internal sources");
  a_pin_drives_low: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  a_hold_stops_core: assert property (reset_pin_oe |=> ##[0:2] !running)
    else $error("core still running during internal reset");
  a_flag_top_ones: assert property (condition_flags[7:5] == 3'h7)
    else $error("flag bits seven to five not one");
  a_sp_high_fixed: assert property (stack_pointer[15:7] == CRS_SP_HIGH_FIXED)
    else $error("stack pointer upper bits changed");
  a_sp_reload: assert property (take && cmd.op == CRS_OP_SP_RELOAD |=> stack_pointer == CRS_SP_RESET)
    else $error("stack pointer not reloaded");
  a_alu_neg_zero: assert property (take && cmd.op == CRS_OP_ALU |=>
    condition_flags[CRS_BIT_N] == $past(cmd.result[7]) && condition_flags[CRS_BIT_Z] == ($past(cmd.result) == 8'h00))
    else $error("negative or zero flag wrong after alu");
  a_int_unmasked: assert property (int_taken |-> !condition_flags[CRS_BIT_I])
    else $error("interrupt taken while masked");
  a_int_five_bytes: assert property (s_entry |-> ##[1:10] s_frame_done)
    else $error("interrupt frame not five bytes with mask set");
  a_int_pcl_first: assert property (s_entry |=> ##[0:2] s_first_write)
    else $error("first stacked byte not counter low");
  a_int_y_kept: assert property (s_entry |=> $stable(index_y) [*5])
    else $error("second index changed by interrupt entry");
  a_call_two: assert property (take && cmd.op == CRS_OP_CALL |=> ##[0:5]
    (stack_pointer == {CRS_SP_HIGH_FIXED, cmd_sp_r[6:0] - 7'h02} && program_counter == cmd_pc_r))
    else $error("call did not use two bytes");
  a_return_unmask: assert property (take && cmd.op == CRS_OP_INT_RETURN |=> ##[1:10] !condition_flags[CRS_BIT_I])
    else $error("mask still set after interrupt return");
endmodule
bind crs_core_regs crs_core_regs_asserts crs_core_regs_asserts_i
(
  .clk(clk), .arst_n(arst_n), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
  .watchdog_reset(watchdog_reset), .low_voltage_reset(low_voltage_reset), .cmd(cmd), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .int_taken(int_taken), .mem(mem), .index_y(index_y), .program_counter(program_counter),
  .condition_flags(condition_flags), .stack_pointer(stack_pointer), .running(running)
);

// >>> verification/crs_core_regs_tb.sv
// Self-checking bench for the register set and stack sequencer
`timescale 1ns/1ps
module crs_core_regs_tb;
  import crs_pkg::*;
  logic clk, arst_n, ext_pin, reset_pin_in, reset_pin_out, reset_pin_oe, watchdog_reset, low_voltage_reset;
  logic cmd_valid, cmd_ready, int_req, int_taken, mem_re, running;
  crs_cmd_t cmd;
  crs_mem_t mem;
  logic [15:0] int_vector, program_counter, stack_pointer;
  logic [7:0] mem_rdata, accumulator, index_x, index_y, condition_flags;
  logic [7:0] ram [0:255];
  int err_count, checked;
  // Open-drain pin: low when either side pulls it
  assign reset_pin_in = ext_pin & ~reset_pin_oe;
  crs_core_regs crs_core_regs_i
  (
    .clk(clk), .arst_n(arst_n), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .watchdog_reset(watchdog_reset), .low_voltage_reset(low_voltage_reset),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .int_req(int_req), .int_vector(int_vector),
    .int_taken(int_taken), .mem(mem), .mem_re(mem_re), .mem_rdata(mem_rdata), .accumulator(accumulator),
    .index_x(index_x), .index_y(index_y), .program_counter(program_counter),
    .condition_flags(condition_flags), .stack_pointer(stack_pointer), .running(running)
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Memory: vector bytes, stack bytes, and a toggling bus when not read
  always @(negedge clk)
  begin
    if (mem.we === 1'b1)
      ram[mem.addr[7:0]] <= mem.wdata;
    if (mem_re === 1'b1)
      mem_rdata <= (mem.addr == 16'hfffe) ? 8'h12 : (mem.addr == 16'hffff) ? 8'h34 : ram[mem.addr[7:0]];
    else
      mem_rdata <= ~mem_rdata;
  end
  task automatic end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input crs_op_t op, input logic [7:0] res, input logic c, input logic h, input logic cv,
    input logic [1:0] dest, input logic [15:0] data);
    int n;
    @(negedge clk);
    cmd = '{op, res, c, h, cv, dest, data};
    cmd_valid = 1'b1;
    for (n = 0; n < 40; n++)
    begin
      #1;
      if (cmd_ready === 1'b1)
        break;
      @(negedge clk);
    end
    if (n == 40)
    begin
      err_count++;
      end_sim();
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic sync;
    issue(CRS_OP_NONE, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
  endtask
  task automatic wait_run;
    int n;
    for (n = 0; n < 6000 && running !== 1'b1; n++)
      @(negedge clk);
    if (n == 6000)
    begin
      err_count++;
      end_sim();
    end
  endtask
  initial
  begin
    err_count = 0;
    checked = 0;
    arst_n = 1'b0;
    ext_pin = 1'b1;
    watchdog_reset = 1'b0;
    low_voltage_reset = 1'b0;
    cmd = '0;
    cmd_valid = 1'b0;
    int_req = 1'b0;
    int_vector = 16'h2000;
    mem_rdata = 8'h00;
    repeat (12) @(negedge clk);
    chk(stack_pointer, CRS_SP_RESET);
    chk(condition_flags, 16'h00e8);
    arst_n = 1'b1;
    wait_run();
    sync();
    chk(program_counter, 16'h1234);
    issue(CRS_OP_ALU, 8'h3c, 1'b0, 1'b0, 1'b0, CRS_DEST_X, 16'h0000);
    issue(CRS_OP_ALU, 8'h77, 1'b0, 1'b0, 1'b0, CRS_DEST_Y, 16'h0000);
    issue(CRS_OP_ALU, 8'h80, 1'b1, 1'b0, 1'b1, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(condition_flags, 16'h00ed);
    chk({index_x, index_y}, 16'h3c77);
    issue(CRS_OP_ALU, 8'h00, 1'b0, 1'b0, 1'b1, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(condition_flags, 16'h00ea);
    issue(CRS_OP_ADD, 8'h5a, 1'b0, 1'b1, 1'b1, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(condition_flags, 16'h00f8);
    issue(CRS_OP_ADD, 8'h5a, 1'b1, 1'b0, 1'b1, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(condition_flags, 16'h00e9);
    chk(accumulator, 16'h005a);
    issue(CRS_OP_CARRY_CLEAR, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(condition_flags, 16'h00e8);
    // Request while masked must wait
    @(negedge clk);
    int_req = 1'b1;
    @(negedge clk);
    int_req = 1'b0;
    repeat (4) @(negedge clk);
    chk(program_counter, 16'h1234);
    issue(CRS_OP_MASK_CLEAR, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(program_counter, 16'h2000);
    chk(stack_pointer, 16'h017a);
    chk(condition_flags, 16'h00e8);
    chk({ram[8'h7f], ram[8'h7e]}, 16'h3412);
    chk({ram[8'h7d], ram[8'h7c]}, 16'h3c5a);
    chk(ram[8'h7b], 16'h00e0);
    chk(index_y, 16'h0077);
    issue(CRS_OP_ALU, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    issue(CRS_OP_INT_RETURN, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk({accumulator, index_x}, 16'h5a3c);
    chk(program_counter, 16'h1234);
    chk(stack_pointer, CRS_SP_RESET);
    chk(condition_flags, 16'h00e0);
    issue(CRS_OP_CALL, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h4321);
    sync();
    chk(program_counter, 16'h4321);
    chk(stack_pointer, 16'h017d);
    chk({ram[8'h7f], ram[8'h7e]}, 16'h3412);
    issue(CRS_OP_RET, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(program_counter, 16'h1234);
    chk(stack_pointer, CRS_SP_RESET);
    issue(CRS_OP_SP_LOAD, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(stack_pointer, 16'h0100);
    issue(CRS_OP_PUSH, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h005a);
    issue(CRS_OP_ALU, 8'h11, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(stack_pointer, CRS_SP_RESET);
    chk(ram[8'h00], 16'h005a);
    issue(CRS_OP_POP, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(stack_pointer, 16'h0100);
    chk(accumulator, 16'h005a);
    issue(CRS_OP_SP_RELOAD, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(stack_pointer, CRS_SP_RESET);
    issue(CRS_OP_CC_LOAD, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0017);
    sync();
    chk(condition_flags, 16'h00f7);
    issue(CRS_OP_MASK_SET, 8'h00, 1'b0, 1'b0, 1'b0, CRS_DEST_ACC, 16'h0000);
    sync();
    chk(condition_flags, 16'h00ff);
    // Internal reset sources pull the pin
    @(negedge clk);
    watchdog_reset = 1'b1;
    #1;
    chk(reset_pin_oe, 16'h0001);
    @(negedge clk);
    watchdog_reset = 1'b0;
    low_voltage_reset = 1'b1;
    #1;
    chk(reset_pin_oe, 16'h0001);
    repeat (3) @(negedge clk);
    chk(running, 16'h0000);
    low_voltage_reset = 1'b0;
    @(negedge clk);
    wait_run();
    sync();
    chk(program_counter, 16'h1234);
    chk(stack_pointer, CRS_SP_RESET);
    ext_pin = 1'b0;
    repeat (2) @(negedge clk);
    ext_pin = 1'b1;
    repeat (3) @(negedge clk);
    chk(running, 16'h0000);
    wait_run();
    sync();
    chk(program_counter, 16'h1234);
    end_sim();
  end
endmodule
